// ---- design/tcc_pkg.sv ----
// Purpose: Shared constants for one timer channel: register map, fields, reset values.
// Assumes: 16-bit channel, 32-bit register port with byte addresses.
// Notes:   Mode register fields change meaning with the waveform select bit.
package tcc_pkg;
    localparam int unsigned ADDR_W  = 32;
    localparam int unsigned DATA_W  = 32;
    localparam int unsigned CNT_W   = 16;

    // Register byte addresses
    localparam logic [31:0] ADDR_CONTROL   = 32'h4001_0000;
    localparam logic [31:0] ADDR_MODE      = 32'h4001_0004;
    localparam logic [31:0] ADDR_STEPPER   = 32'h4001_0008;
    localparam logic [31:0] ADDR_READOUT   = 32'h4001_000C;
    localparam logic [31:0] ADDR_COUNTER   = 32'h4001_0010;
    localparam logic [31:0] ADDR_CMP_A     = 32'h4001_0014;
    localparam logic [31:0] ADDR_CMP_B     = 32'h4001_0018;
    localparam logic [31:0] ADDR_PERIOD    = 32'h4001_001C;
    localparam logic [31:0] ADDR_STATUS    = 32'h4001_0020;
    localparam logic [31:0] ADDR_WPROT     = 32'h4001_00E4;

    // Control register bits (write-only strobes)
    localparam int unsigned CTL_CLK_EN  = 0;
    localparam int unsigned CTL_CLK_DIS = 1;
    localparam int unsigned CTL_SW_TRIG = 2;

    // Mode register fields
    localparam int unsigned MODE_RESTART  = 14;
    localparam int unsigned MODE_WAVE     = 15;
    localparam int unsigned MODE_LOAD_A   = 16;
    localparam int unsigned MODE_LOAD_B   = 18;
    localparam int unsigned MODE_A_CMPA   = 16;
    localparam int unsigned MODE_A_PER    = 18;
    localparam int unsigned MODE_A_EXT    = 20;
    localparam int unsigned MODE_A_SW     = 22;
    localparam int unsigned MODE_B_CMPB   = 24;
    localparam int unsigned MODE_B_PER    = 26;
    localparam int unsigned MODE_B_EXT    = 28;
    localparam int unsigned MODE_B_SW     = 30;

    // Stepper register fields
    localparam int unsigned STEP_GRAY_EN  = 0;
    localparam int unsigned STEP_DOWN     = 1;

    // Write protection field
    localparam int unsigned WPROT_LOCK    = 0;

    // Status register bit positions
    localparam int unsigned ST_OVF    = 0;
    localparam int unsigned ST_OVR    = 1;
    localparam int unsigned ST_CMPA   = 2;
    localparam int unsigned ST_CMPB   = 3;
    localparam int unsigned ST_PER    = 4;
    localparam int unsigned ST_LDA    = 5;
    localparam int unsigned ST_LDB    = 6;
    localparam int unsigned ST_CLKON  = 16;
    localparam int unsigned ST_MIRA   = 17;
    localparam int unsigned ST_MIRB   = 18;

    // Line action codes
    localparam logic [1:0] ACT_NONE   = 2'h0;
    localparam logic [1:0] ACT_SET    = 2'h1;
    localparam logic [1:0] ACT_CLEAR  = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;

    // Load edge codes
    localparam logic [1:0] EDGE_NONE    = 2'h0;
    localparam logic [1:0] EDGE_RISING  = 2'h1;
    localparam logic [1:0] EDGE_FALLING = 2'h2;
    localparam logic [1:0] EDGE_BOTH    = 2'h3;

    // Reset values
    localparam logic [31:0] RST_WORD  = 32'h0000_0000;
    localparam logic [15:0] RST_CNT   = 16'h0000;
    localparam logic [15:0] CNT_MAX   = 16'hFFFF;
    localparam logic [15:0] CNT_ONE   = 16'h0001;
    localparam logic [1:0]  GRAY_RST  = 2'h0;
    localparam logic [1:0]  GRAY_ONE  = 2'h1;
endpackage : tcc_pkg

// ---- design/tcc_channel.sv ----
// Purpose: One 16-bit timer channel: counter, compares, line actions, capture queue, status.
// Assumes: count_tick_in and ext_event_in are one-cycle pulses from logic on clk_sys_in.
// Notes:   Line pins are two-way; line inputs pass a two-flop synchroniser before use.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module tcc_channel #(
    parameter int unsigned QUEUE_DEPTH = 4,
    parameter int unsigned QUEUE_AW    = 2
) (
    input  wire logic                        clk_sys_in,
    input  wire logic                        rstn_in,
    input  wire logic [tcc_pkg::ADDR_W-1:0]  reg_addr_in,
    input  wire logic [tcc_pkg::DATA_W-1:0]  reg_wdata_in,
    input  wire logic                        reg_wr_in,
    input  wire logic                        reg_rd_in,
    output logic      [tcc_pkg::DATA_W-1:0]  reg_rdata_out,
    input  wire logic                        count_tick_in,
    input  wire logic                        ext_event_in,
    input  wire logic                        line_a_in,
    output logic                             line_a_out,
    output logic                             line_a_oe_out,
    input  wire logic                        line_b_in,
    output logic                             line_b_out,
    output logic                             line_b_oe_out,
    output logic                             dma_req_out
);
    import tcc_pkg::*;

    typedef logic [CNT_W-1:0] tcc_cnt_type;
    tcc_cnt_type       count_reg, count_next;
    tcc_cnt_type       cmp_a_reg, cmp_a_next;
    tcc_cnt_type       cmp_b_reg, cmp_b_next;
    tcc_cnt_type       period_reg, period_next;
    logic [31:0]       mode_reg, mode_next;
    logic [1:0]        step_reg, step_next;
    logic              lock_reg, lock_next;
    logic              clk_on_reg, clk_on_next;
    logic [1:0]        gray_reg, gray_next;
    logic              out_a_reg, out_a_next;
    logic              out_b_reg, out_b_next;
    logic [6:0]        flags_reg, flags_next;
    logic              unread_a_reg, unread_a_next;
    logic              unread_b_reg, unread_b_next;
    logic [31:0]       rdata_reg, rdata_next;
    logic [1:0]        sync_a_reg, sync_b_reg;
    logic              prev_a_reg;
    tcc_cnt_type       queue_mem [QUEUE_DEPTH];
    logic [QUEUE_AW-1:0] wr_ptr_reg, rd_ptr_reg;
    logic [QUEUE_AW:0]   fill_reg, fill_next;

    // Address decode
    wire hit_ctl    = reg_addr_in == ADDR_CONTROL;
    wire hit_mode   = reg_addr_in == ADDR_MODE;
    wire hit_step   = reg_addr_in == ADDR_STEPPER;
    wire hit_rdout  = reg_addr_in == ADDR_READOUT;
    wire hit_cnt    = reg_addr_in == ADDR_COUNTER;
    wire hit_cmpa   = reg_addr_in == ADDR_CMP_A;
    wire hit_cmpb   = reg_addr_in == ADDR_CMP_B;
    wire hit_per    = reg_addr_in == ADDR_PERIOD;
    wire hit_stat   = reg_addr_in == ADDR_STATUS;
    wire hit_wprot  = reg_addr_in == ADDR_WPROT;
    wire wave_mode  = mode_reg[MODE_WAVE];
    wire wr_open    = reg_wr_in && !lock_reg;
    wire wr_cmpa    = wr_open && hit_cmpa && wave_mode;
    wire wr_cmpb    = wr_open && hit_cmpb && wave_mode;
    wire wr_per     = wr_open && hit_per;
    wire wr_mode    = wr_open && hit_mode;
    wire wr_step    = wr_open && hit_step;
    wire wr_ctl     = reg_wr_in && hit_ctl;
    wire sw_trig    = wr_ctl && reg_wdata_in[CTL_SW_TRIG];
    wire rd_stat    = reg_rd_in && hit_stat;
    // Counter events
    wire tick       = count_tick_in && clk_on_reg;
    wire at_max     = count_reg == CNT_MAX;
    wire per_hit    = tick && (count_reg == period_reg);
    wire cmpa_hit   = tick && wave_mode && (count_reg == cmp_a_reg);
    wire cmpb_hit   = tick && wave_mode && (count_reg == cmp_b_reg);
    wire ovf_hit    = tick && at_max;
    wire ext_evt    = ext_event_in && wave_mode;
    // Capture edges on the synchronised line A
    wire pin_a      = sync_a_reg[1];
    wire rise_a     = pin_a && !prev_a_reg;
    wire fall_a     = !pin_a && prev_a_reg;
    wire [1:0] lda  = mode_reg[MODE_LOAD_A +: 2];
    wire [1:0] ldb  = mode_reg[MODE_LOAD_B +: 2];
    wire load_a     = !wave_mode && (((lda == EDGE_RISING) || (lda == EDGE_BOTH)) && rise_a
                      || ((lda == EDGE_FALLING) || (lda == EDGE_BOTH)) && fall_a);
    wire load_b     = !wave_mode && (((ldb == EDGE_RISING) || (ldb == EDGE_BOTH)) && rise_a
                      || ((ldb == EDGE_FALLING) || (ldb == EDGE_BOTH)) && fall_a);
    // Capture queue control
    wire q_empty    = fill_reg == '0;
    wire q_pop      = reg_rd_in && hit_rdout && !q_empty;
    wire [QUEUE_AW:0] q_space = (QUEUE_AW+1)'(QUEUE_DEPTH) - fill_reg;
    wire q_push_a   = load_a && (q_space != '0 || q_pop);
    wire q_push_b   = load_b && ((QUEUE_AW+1)'(q_space) > (QUEUE_AW+1)'(q_push_a)
                      || (q_pop && q_space == (QUEUE_AW+1)'(q_push_a)));

    // Apply one action code to a line level
    function automatic logic apply_act(input logic cur, input logic [1:0] code);
        logic res;
        res = cur;
        case (code)
            ACT_SET:    res = 1'b1;
            ACT_CLEAR:  res = 1'b0;
            ACT_TOGGLE: res = !cur;
            default:    res = cur;
        endcase
        return res;
    endfunction : apply_act

    // Lines A and B: lowest priority first so trigger wins
    always_comb begin
        out_a_next = out_a_reg;
        out_b_next = out_b_reg;
        if (wave_mode) begin
            if (cmpa_hit) begin
                out_a_next = apply_act(out_a_next, mode_reg[MODE_A_CMPA +: 2]);
            end
            if (per_hit) begin
                out_a_next = apply_act(out_a_next, mode_reg[MODE_A_PER +: 2]);
            end
            if (ext_evt) begin
                out_a_next = apply_act(out_a_next, mode_reg[MODE_A_EXT +: 2]);
            end
            if (sw_trig) begin
                out_a_next = apply_act(out_a_next, mode_reg[MODE_A_SW +: 2]);
            end
            if (cmpb_hit) begin
                out_b_next = apply_act(out_b_next, mode_reg[MODE_B_CMPB +: 2]);
            end
            if (per_hit) begin
                out_b_next = apply_act(out_b_next, mode_reg[MODE_B_PER +: 2]);
            end
            if (ext_evt) begin
                out_b_next = apply_act(out_b_next, mode_reg[MODE_B_EXT +: 2]);
            end
            if (sw_trig) begin
                out_b_next = apply_act(out_b_next, mode_reg[MODE_B_SW +: 2]);
            end
        end
    end

    always_comb begin
        gray_next = gray_reg;
        if (per_hit && step_reg[STEP_GRAY_EN]) begin
            case ({step_reg[STEP_DOWN], gray_reg})
                3'h0:    gray_next = 2'h1;
                3'h1:    gray_next = 2'h3;
                3'h3:    gray_next = 2'h2;
                3'h2:    gray_next = 2'h0;
                3'h4:    gray_next = 2'h2;
                3'h6:    gray_next = 2'h3;
                3'h7:    gray_next = 2'h1;
                3'h5:    gray_next = 2'h0;
                default: gray_next = GRAY_RST;
            endcase
        end
    end
    // Counter: wraps at top, restarts on trigger or on period match if asked
    always_comb begin
        count_next = count_reg;
        if (sw_trig || (per_hit && mode_reg[MODE_RESTART])) begin
            count_next = RST_CNT;
        end else if (tick) begin
            count_next = count_reg + CNT_ONE;
        end
    end

    always_comb begin
        clk_on_next = clk_on_reg;
        if (wr_ctl && reg_wdata_in[CTL_CLK_DIS]) begin
            clk_on_next = 1'b0;
        end else if (wr_ctl && reg_wdata_in[CTL_CLK_EN]) begin
            clk_on_next = 1'b1;
        end
        cmp_a_next  = wr_cmpa ? reg_wdata_in[CNT_W-1:0] : (load_a ? count_reg : cmp_a_reg);
        cmp_b_next  = wr_cmpb ? reg_wdata_in[CNT_W-1:0] : (load_b ? count_reg : cmp_b_reg);
        period_next = wr_per ? reg_wdata_in[CNT_W-1:0] : period_reg;
        mode_next   = wr_mode ? reg_wdata_in : mode_reg;
        step_next   = wr_step ? reg_wdata_in[1:0] : step_reg;
        lock_next   = (reg_wr_in && hit_wprot) ? reg_wdata_in[WPROT_LOCK] : lock_reg;
    end

    // Unread tracking: a register read clears, a load marks unread
    always_comb begin
        unread_a_next = unread_a_reg;
        unread_b_next = unread_b_reg;
        if (reg_rd_in && hit_cmpa) begin
            unread_a_next = 1'b0;
        end
        if (reg_rd_in && hit_cmpb) begin
            unread_b_next = 1'b0;
        end
        if (load_a) begin
            unread_a_next = 1'b1;
        end
        if (load_b) begin
            unread_b_next = 1'b1;
        end
        if (wave_mode) begin
            unread_a_next = 1'b0;
            unread_b_next = 1'b0;
        end
    end

    // Status flags: clear on read, then any event of this cycle sets again
    always_comb begin
        flags_next = rd_stat ? 7'h00 : flags_reg;
        if (ovf_hit) begin
            flags_next[ST_OVF] = 1'b1;
        end
        if ((load_a && unread_a_reg) || (load_b && unread_b_reg)) begin
            flags_next[ST_OVR] = 1'b1;
        end
        if (cmpa_hit) begin
            flags_next[ST_CMPA] = 1'b1;
        end
        if (cmpb_hit) begin
            flags_next[ST_CMPB] = 1'b1;
        end
        if (per_hit) begin
            flags_next[ST_PER] = 1'b1;
        end
        if (load_a) begin
            flags_next[ST_LDA] = 1'b1;
        end
        if (load_b) begin
            flags_next[ST_LDB] = 1'b1;
        end
        // Capture-only and waveform-only flags hold zero in the other mode
        if (wave_mode) begin
            flags_next[ST_OVR] = 1'b0;
            flags_next[ST_LDA] = 1'b0;
            flags_next[ST_LDB] = 1'b0;
        end else begin
            flags_next[ST_CMPA] = 1'b0;
            flags_next[ST_CMPB] = 1'b0;
        end
    end

    // Mirrors show the driven level in waveform mode, the pin in capture mode
    wire mirror_a = wave_mode ? line_a_out : pin_a;
    wire mirror_b = wave_mode ? line_b_out : sync_b_reg[1];
    wire [31:0] status_word = {13'h0000, mirror_b, mirror_a, clk_on_reg, 9'h000, flags_reg};
    // Read mux; unmapped or write-only addresses read zero
    always_comb begin
        rdata_next = RST_WORD;
        if (reg_rd_in) begin
            if (hit_mode) begin
                rdata_next = mode_reg;
            end else if (hit_step) begin
                rdata_next = {30'h0000_0000, step_reg};
            end else if (hit_rdout) begin
                rdata_next = {16'h0000, queue_mem[rd_ptr_reg]};
            end else if (hit_cnt) begin
                rdata_next = {16'h0000, count_reg};
            end else if (hit_cmpa) begin
                rdata_next = {16'h0000, cmp_a_reg};
            end else if (hit_cmpb) begin
                rdata_next = {16'h0000, cmp_b_reg};
            end else if (hit_per) begin
                rdata_next = {16'h0000, period_reg};
            end else if (hit_stat) begin
                rdata_next = status_word;
            end else if (hit_wprot) begin
                rdata_next = {31'h0000_0000, lock_reg};
            end
        end
    end

    assign fill_next = fill_reg + (QUEUE_AW+1)'(q_push_a) + (QUEUE_AW+1)'(q_push_b)
                       - (QUEUE_AW+1)'(q_pop);
    // Queue storage; B lands after A when both load together
    always_ff @(posedge clk_sys_in) begin
        if (q_push_a) begin
            queue_mem[wr_ptr_reg] <= count_reg;
        end
        if (q_push_b) begin
            queue_mem[wr_ptr_reg + QUEUE_AW'(q_push_a)] <= count_reg;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            fill_reg   <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + QUEUE_AW'(q_push_a) + QUEUE_AW'(q_push_b);
            rd_ptr_reg <= rd_ptr_reg + QUEUE_AW'(q_pop);
            fill_reg   <= fill_next;
        end
    end

    // First stage is read only by the second stage
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sync_a_reg <= 2'h0;
            sync_b_reg <= 2'h0;
            prev_a_reg <= 1'b0;
        end else begin
            sync_a_reg <= {sync_a_reg[0], line_a_in};
            sync_b_reg <= {sync_b_reg[0], line_b_in};
            prev_a_reg <= sync_a_reg[1];
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            count_reg    <= RST_CNT;
            cmp_a_reg    <= RST_CNT;
            cmp_b_reg    <= RST_CNT;
            period_reg   <= RST_CNT;
            mode_reg     <= RST_WORD;
            step_reg     <= 2'h0;
            lock_reg     <= 1'b0;
            clk_on_reg   <= 1'b0;
            gray_reg     <= GRAY_RST;
            out_a_reg    <= 1'b0;
            out_b_reg    <= 1'b0;
            flags_reg    <= 7'h00;
            unread_a_reg <= 1'b0;
            unread_b_reg <= 1'b0;
            rdata_reg    <= RST_WORD;
        end else begin
            count_reg    <= count_next;
            cmp_a_reg    <= cmp_a_next;
            cmp_b_reg    <= cmp_b_next;
            period_reg   <= period_next;
            mode_reg     <= mode_next;
            step_reg     <= step_next;
            lock_reg     <= lock_next;
            clk_on_reg   <= clk_on_next;
            gray_reg     <= gray_next;
            out_a_reg    <= out_a_next;
            out_b_reg    <= out_b_next;
            flags_reg    <= flags_next;
            unread_a_reg <= unread_a_next;
            unread_b_reg <= unread_b_next;
            rdata_reg    <= rdata_next;
        end
    end

    // gray counter takes over both lines
    assign line_a_out    = step_reg[STEP_GRAY_EN] ? gray_reg[0] : out_a_reg;
    assign line_b_out    = step_reg[STEP_GRAY_EN] ? gray_reg[1] : out_b_reg;
    // Capture mode needs line A as an input, so lines drive only in waveform or gray
    assign line_a_oe_out = wave_mode || step_reg[STEP_GRAY_EN];
    assign line_b_oe_out = wave_mode || step_reg[STEP_GRAY_EN];
    assign reg_rdata_out = rdata_reg;
    assign dma_req_out   = !q_empty;
endmodule : tcc_channel

// ---- verification/tcc_line_model.sv ----
// Purpose: Far-side circuit on the two channel lines.
// Assumes: Line B carries a pull-up; the bench drives line A when capturing.
// Notes:   Device drive wins whenever its enable is high.
`timescale 1ns/1ps
module tcc_line_model (
    input  wire logic dev_a_in,
    input  wire logic dev_a_oe_in,
    input  wire logic dev_b_in,
    input  wire logic dev_b_oe_in,
    input  wire logic ext_a_in,
    output logic      pin_a_out,
    output logic      pin_b_out
);
    assign pin_a_out = dev_a_oe_in ? dev_a_in : ext_a_in;
    // Released line B floats to its pull-up
    assign pin_b_out = dev_b_oe_in ? dev_b_in : 1'b1;
endmodule : tcc_line_model

// ---- verification/tcc_channel_checker.sv ----
// Purpose: Port assertions for one timer channel.
// Assumes: Read data stand only in the cycle after the read strobe.
// Notes:   Bound to every channel instance.
`timescale 1ns/1ps
module tcc_channel_checker
    import tcc_pkg::*;
(
    input wire logic        clk_sys_in,
    input wire logic        rstn_in,
    input wire logic [31:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic        count_tick_in,
    input wire logic        ext_event_in,
    input wire logic        line_a_in,
    input wire logic        line_a_out,
    input wire logic        line_a_oe_out,
    input wire logic        line_b_in,
    input wire logic        line_b_out,
    input wire logic        line_b_oe_out,
    input wire logic        dma_req_out
);
    logic [2:0] since_edge_reg;
    // A capture load just after a line edge may set overrun within the read cycle
    wire rd_st  = reg_rd_in && reg_addr_in == ADDR_STATUS && !count_tick_in
                  && since_edge_reg > 3'h3;
    wire rd_cnt = reg_rd_in && reg_addr_in == ADDR_COUNTER && !count_tick_in && !reg_wr_in;
    wire rd_16  = reg_rd_in && reg_addr_in inside {ADDR_COUNTER, ADDR_CMP_A, ADDR_PERIOD};
    wire cause  = count_tick_in || ext_event_in || reg_wr_in;
    // Saturates so an old line edge cannot excuse a late request
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in)
            since_edge_reg <= 3'h7;
        else if ($changed(line_a_in))
            since_edge_reg <= 3'h0;
        else if (since_edge_reg != 3'h7)
            since_edge_reg <= since_edge_reg + 3'h1;
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    a_rdata_one_cycle: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
        else $error("read data outside answer cycle");
    a_upper_bits_zero: assert property (rd_16 |=> reg_rdata_out[31:16] == 16'h0)
        else $error("count upper bits set");
    a_count_live: assert property (rd_cnt ##1 rd_cnt |=> $stable(reg_rdata_out))
        else $error("count moved without tick");
    a_status_cleared: assert property (rd_st ##1 rd_st |=> reg_rdata_out[4:0] == 5'h0)
        else $error("flag survived status read");
    a_dma_after_edge: assert property ($rose(dma_req_out) |-> since_edge_reg != 3'h7)
        else $error("request without line edge");
    a_dma_pop_only: assert property ($fell(dma_req_out) |-> $past(reg_rd_in)
        && $past(reg_addr_in) == ADDR_READOUT) else $error("request dropped without pop");
    a_line_a_cause: assert property ($changed(line_a_out) |-> $past(cause))
        else $error("line A moved without cause");
    a_line_b_cause: assert property ($changed(line_b_out) |-> $past(cause))
        else $error("line B moved without cause");
endmodule : tcc_channel_checker
bind tcc_channel tcc_channel_checker tcc_channel_checker_inst (.clk_sys_in, .rstn_in,
    .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .count_tick_in,
    .ext_event_in, .line_a_in, .line_a_out, .line_a_oe_out, .line_b_in, .line_b_out,
    .line_b_oe_out, .dma_req_out);

// ---- verification/timer_channel_output_capture_regs_tb_top.sv ----
// Purpose: Self-checking bench for one timer channel against an integer model.
// Assumes: Period stays 0 in line tests, so every tick is a period match.
// Notes:   Captures reach the channel through the line model.
`timescale 1ns/1ps
module timer_channel_output_capture_regs_tb_top;
    import tcc_pkg::*;
    logic        clk_sys_in = 1'b0;
    logic        rstn_in = 1'b0;
    logic [31:0] addr = 32'h0, wdata = 32'h0, rdata, d1, d2;
    logic        wr = 1'b0, rd = 1'b0, tick = 1'b0, ev = 1'b0, ext_a = 1'b0;
    logic        pin_a, pin_b, a_out, a_oe, b_out, b_oe, dma_req;
    logic [31:0] regs [5] = '{ADDR_STEPPER, ADDR_COUNTER, ADDR_CMP_A, ADDR_PERIOD, ADDR_STATUS};
    int          miscompares = 0, checked = 0, cycles = 0, la = 0, lb = 0, cnt = 0, g = 0;
    int          q[$];
    int unsigned rnd;
    tcc_channel tcc_channel_inst (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .count_tick_in(tick), .ext_event_in(ev), .line_a_in(pin_a), .line_a_out(a_out),
        .line_a_oe_out(a_oe), .line_b_in(pin_b), .line_b_out(b_out), .line_b_oe_out(b_oe),
        .dma_req_out(dma_req));
    tcc_line_model tcc_line_model_inst (.dev_a_in(a_out), .dev_a_oe_in(a_oe), .dev_b_in(b_out),
        .dev_b_oe_in(b_oe), .ext_a_in(ext_a), .pin_a_out(pin_a), .pin_b_out(pin_b));
    initial begin
        forever #25 clk_sys_in = ~clk_sys_in;
    end
    task automatic conclude;
        $display("Counts: %0d checked, %0d miscompares", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : cmp
    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys_in);
        wr <= 1'b0;
        #1;
    endtask : wr_reg
    // Two back-to-back reads of one address
    task automatic rd2(input logic [31:0] a, output logic [31:0] r1, output logic [31:0] r2);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_in);
        #1 r1 = rdata;
        @(posedge clk_sys_in);
        rd <= 1'b0;
        #1 r2 = rdata;
    endtask : rd2
    task automatic pulse(input logic is_tick);
        tick <= is_tick;
        ev <= !is_tick;
        cnt += is_tick;
        @(posedge clk_sys_in);
        tick <= 1'b0;
        ev <= 1'b0;
        @(posedge clk_sys_in);
        #1;
    endtask : pulse
    // Rise then fall; both load fields take the rise, so A then B each queue one value
    task automatic edge_a;
        ext_a <= 1'b1;
        q.push_back(cnt);
        q.push_back(cnt);
        repeat (6) @(posedge clk_sys_in);
        ext_a <= 1'b0;
        repeat (6) @(posedge clk_sys_in);
        #1;
    endtask : edge_a
    function automatic int act(input int cur, input int code);
        return (code == 1) ? 1 : (code == 2) ? 0 : (code == 3) ? 1 - cur : cur;
    endfunction : act
    initial begin
        rnd = $urandom(28);
        repeat (4) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        @(posedge clk_sys_in);
        #1;
        foreach (regs[i]) begin
            rd2(regs[i], d1, d2);
            cmp(d1 & (regs[i] == ADDR_STATUS ? 32'h7F : 32'hFFFF_FFFF), 32'h0);
        end
        $display("Test reset values done");
        wr_reg(ADDR_MODE, 32'h0000_4000);
        wr_reg(ADDR_CONTROL, 32'h1);
        wr_reg(ADDR_STEPPER, 32'h1);
        for (int i = 0; i < 8; i++) begin
            if (i == 4)
                wr_reg(ADDR_STEPPER, 32'h3);
            pulse(1'b1);
            g = (i < 4) ? (g + 1) % 4 : (g + 3) % 4;
            cmp(32'({b_out, a_out}), 32'(g ^ (g >> 1)));
        end
        $display("Test gray stepping done");
        wr_reg(ADDR_STEPPER, 32'h0);
        // Compare actions stay zero so only the three causes move the lines
        for (int i = 0; i < 8; i++) begin
            rnd = $urandom & 32'hFCFC_0000;
            wr_reg(ADDR_MODE, rnd | 32'h0000_C000);
            wr_reg(ADDR_CONTROL, 32'h5);
            la = act(la, rnd[23:22]);
            lb = act(lb, rnd[31:30]);
            cmp(32'({b_out, a_out}), 32'(lb * 2 + la));
            pulse(1'b0);
            la = act(la, rnd[21:20]);
            lb = act(lb, rnd[29:28]);
            cmp(32'({b_out, a_out}), 32'(lb * 2 + la));
            pulse(1'b1);
            la = act(la, rnd[19:18]);
            lb = act(lb, rnd[27:26]);
            cmp(32'({b_out, a_out}), 32'(lb * 2 + la));
        end
        rd2(ADDR_STATUS, d1, d2);
        cmp(d1 & 32'h7F, 32'h1C);
        cmp(d2 & 32'h7F, 32'h0);
        cmp(32'({b_oe, a_oe}), 32'h3);
        wr_reg(ADDR_MODE, 32'h0300_C000);
        pulse(1'b1);
        lb = act(lb, 3);
        cmp(32'({b_out, a_out}), 32'(lb * 2 + la));
        $display("Test line actions done");
        rnd = $urandom & 32'hFFFF;
        wr_reg(ADDR_CMP_A, rnd | 32'hFFFF_0000);
        wr_reg(ADDR_PERIOD, rnd | 32'hFFFF_0000);
        wr_reg(ADDR_WPROT, 32'h1);
        wr_reg(ADDR_PERIOD, 32'h0);
        rd2(ADDR_PERIOD, d1, d2);
        cmp(d1, rnd);
        wr_reg(ADDR_WPROT, 32'h0);
        wr_reg(ADDR_PERIOD, 32'h0);
        wr_reg(ADDR_MODE, 32'h0005_0000);
        wr_reg(ADDR_CMP_A, 32'h0);
        rd2(ADDR_CMP_A, d1, d2);
        cmp(d1, rnd);
        rd2(ADDR_PERIOD, d1, d2);
        cmp(d1, 32'h0);
        rd2(32'h4001_0030, d1, d2);
        cmp(d1, 32'h0);
        $display("Test access and lock done");
        wr_reg(ADDR_CONTROL, 32'h5);
        cnt = 0;
        cmp(32'({b_oe, a_oe}), 32'h0);
        rd2(ADDR_STATUS, d1, d2);
        repeat (3) pulse(1'b1);
        edge_a();
        pulse(1'b1);
        edge_a();
        cmp(32'(dma_req), 32'h1);
        repeat (2) begin
            rd2(ADDR_READOUT, d1, d2);
            cmp(d1, 32'(q.pop_front()));
            cmp(d2, 32'(q.pop_front()));
        end
        cmp(32'(dma_req), 32'h0);
        edge_a();
        rd2(ADDR_STATUS, d1, d2);
        cmp(d1 & 32'h7F, 32'h72);
        $display("Test capture queue done");
        conclude();
    end
endmodule : timer_channel_output_capture_regs_tb_top
